// File: rtl/bmc_pkg.sv
`default_nettype none
package bmc_pkg;
  // word and field widths
  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int DP_W = 9;
  localparam int DMA_W = 7;
  localparam int ARF_W = 7;
  localparam int CNT_W = 17;
  localparam int CTL_W = 6;
  localparam int STACK_DEPTH = 8;

  // opcode patterns of the first instruction word
  localparam logic [7:0] OP_MOVE_HI = 8'hA5;
  localparam logic [7:0] OP_CALL_HI = 8'h7A;
  localparam logic [5:0] OP_CC_HI = 6'h3A;
  localparam logic [15:0] OP_COMPUTED_SUBROUTINE_CALL = 16'hBE30;
  localparam logic [11:0] OP_CLEAR_CONTROL_BIT_INSTR_HI = 12'hBE4;
  localparam int IND_BIT = 7;

  // conditional call fields: tp [9:8], flag mask [7:4], flag value [3:0]
  localparam int TP_LSB = 8;
  localparam int MASK_LSB = 4;
  localparam logic [1:0] TP_BIO = 2'h0;
  localparam logic [1:0] TP_TC = 2'h1;
  localparam logic [1:0] TP_NTC = 2'h2;
  localparam logic [1:0] TP_NONE = 2'h3;

  // control bit positions and their reset value
  localparam int CTL_C = 0;
  localparam int CTL_CNF = 1;
  localparam int CTL_GLOBAL_INTERRUPT_MASK = 2;
  localparam int CTL_OVM = 3;
  localparam int CTL_SXM = 4;
  localparam int CTL_TC = 5;
  localparam logic [5:0] CTL_RESET = 6'h04;

  // select codes in the low nibble of the clear-control-bit word
  localparam logic [3:0] SEL_GLOBAL_INTERRUPT_MASK = 4'h0;
  localparam logic [3:0] SEL_OVM = 4'h2;
  localparam logic [3:0] SEL_CNF = 4'h4;
  localparam logic [3:0] SEL_SXM = 4'h6;
  localparam logic [3:0] SEL_TC = 4'hA;
  localparam logic [3:0] SEL_C = 4'hE;

  // cycle figures of the calls
  localparam int CALL_CYCLES = 4;
  localparam logic [1:0] HOLD_COMPUTED_SUBROUTINE_CALL = 2'(CALL_CYCLES - 1);
  localparam logic [1:0] HOLD_CALL = 2'(CALL_CYCLES - 2);
  localparam logic [1:0] HOLD_LAST = 2'h1;

  // pc steps
  localparam logic [15:0] PC_ONE = 16'h0001;
  localparam logic [15:0] PC_TWO = 16'h0002;
  localparam logic [16:0] WORDS_ONE = 17'h00001;

  typedef enum logic [1:0] {ST_OPC, ST_WORD2, ST_MOVE, ST_FLUSH} bmc_state_e;
  typedef enum logic [2:0] {CLS_MOVE, CLS_COMPUTED_SUBROUTINE_CALL, CLS_CALL, CLS_CC, CLS_CLEAR_CONTROL_BIT_INSTR, CLS_OTHER} bmc_class_e;

  // one data-memory write
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } bmc_dmw_s;

  // sort a first word into the handled instruction classes
  function automatic bmc_class_e bmc_classify(input logic [15:0] w);
    bmc_class_e c;
    c = CLS_OTHER;
    if (w[15:8] == OP_MOVE_HI)
      c = CLS_MOVE;
    else if (w == OP_COMPUTED_SUBROUTINE_CALL)
      c = CLS_COMPUTED_SUBROUTINE_CALL;
    else if (w[15:8] == OP_CALL_HI)
      c = CLS_CALL;
    else if (w[15:10] == OP_CC_HI)
      c = CLS_CC;
    else if (w[15:4] == OP_CLEAR_CONTROL_BIT_INSTR_HI)
      c = CLS_CLEAR_CONTROL_BIT_INSTR;
    return c;
  endfunction : bmc_classify

  // one-hot clear mask from the select nibble
  function automatic logic [5:0] bmc_clear_control_bit_instr_sel(input logic [3:0] s);
    logic [5:0] m;
    m = '0;
    case (s)
      SEL_C: m[CTL_C] = 1'b1;
      SEL_CNF: m[CTL_CNF] = 1'b1;
      SEL_GLOBAL_INTERRUPT_MASK: m[CTL_GLOBAL_INTERRUPT_MASK] = 1'b1;
      SEL_OVM: m[CTL_OVM] = 1'b1;
      SEL_SXM: m[CTL_SXM] = 1'b1;
      SEL_TC: m[CTL_TC] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction : bmc_clear_control_bit_instr_sel
endpackage : bmc_pkg
`default_nettype wire

// File: rtl/bmc_stack.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_stack (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // push and pop
  input wire logic push,
  input wire logic [15:0] push_data,
  input wire logic pop,
  // top entry
  output logic [15:0] stack_top_entry
);
  logic [15:0] stk_ff [bmc_pkg::STACK_DEPTH];

  // shift register stack, entry 0 is the top
  genvar i;
  generate
    for (i = 0; i < bmc_pkg::STACK_DEPTH; i++)
    begin : g_ent
      logic [15:0] below;
      logic [15:0] above;
      assign above = (i == 0) ? push_data : stk_ff[(i == 0) ? 0 : i - 1];
      assign below = (i == bmc_pkg::STACK_DEPTH - 1) ? stk_ff[i] : stk_ff[(i == bmc_pkg::STACK_DEPTH - 1) ? i : i + 1];
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          stk_ff[i] <= '0;
        else if (push)
          stk_ff[i] <= above;
        else if (pop)
          stk_ff[i] <= below;
      end
    end
  endgenerate

  assign stack_top_entry = stk_ff[0];
endmodule : bmc_stack
`default_nettype wire

// File: rtl/bmc_buf.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_buf (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  input wire bmc_pkg::bmc_dmw_s in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output bmc_pkg::bmc_dmw_s out_data,
  input wire logic out_ready,
  // occupancy
  output logic [1:0] level
);
  logic out_valid_ff;
  logic skid_valid_ff;
  bmc_pkg::bmc_dmw_s out_ff;
  bmc_pkg::bmc_dmw_s skid_ff;
  logic pop;
  logic push;
  logic head_free;

  // handshake terms
  assign pop = out_valid_ff && out_ready;
  assign push = in_valid && !skid_valid_ff;
  assign head_free = !out_valid_ff || pop;

  // head register with one skid entry behind it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      out_valid_ff <= 1'b0;
      skid_valid_ff <= 1'b0;
      out_ff <= '0;
      skid_ff <= '0;
    end
    else if (head_free)
    begin
      out_ff <= skid_valid_ff ? skid_ff : in_data;
      out_valid_ff <= skid_valid_ff || push;
      skid_valid_ff <= 1'b0;
    end
    else if (push)
    begin
      skid_ff <= in_data;
      skid_valid_ff <= 1'b1;
    end
  end

  assign in_ready = !skid_valid_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_ff;
  assign level = {1'b0, out_valid_ff} + {1'b0, skid_valid_ff};
endmodule : bmc_buf
`default_nettype wire

// File: rtl/bmc_exec.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_exec (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // instruction word stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  // pipeline control
  output logic [15:0] pc_out,
  output logic flush,
  output logic int_hold,
  // repeat prefix
  input wire logic rpt_pending,
  input wire logic [15:0] rpt_count,
  // operands from the core
  input wire logic [31:0] acc_value,
  input wire logic ovf_flag,
  input wire logic [8:0] dp_value,
  input wire logic [15:0] aux_value,
  // auxiliary register step
  output logic ar_step,
  output logic [6:0] ar_field,
  // program memory read
  output logic pm_req,
  output logic [15:0] pm_addr,
  input wire logic pm_rvalid,
  input wire logic [15:0] pm_rdata,
  // data memory write
  output logic dm_valid,
  output logic [15:0] dm_addr,
  output logic [15:0] dm_data,
  input wire logic dm_ready,
  // hardware stack
  input wire logic stack_pop,
  output logic [15:0] stack_top,
  // control bits
  input wire logic [5:0] ctl_set,
  output logic [5:0] ctl_bits,
  // branch input pin
  input wire logic bio_pin_n
);
  bmc_pkg::bmc_state_e state_ff, nxt_state;
  bmc_pkg::bmc_class_e cls_ff;
  bmc_pkg::bmc_class_e cls_now;
  logic [15:0] opcode_ff;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] mstack_ff;
  logic [16:0] words_left_ff;
  logic [1:0] hold_ff;
  logic instr_ready_ff, nxt_ready;
  logic flush_ff, int_hold_ff, rpt_mode_ff;
  logic pm_req_ff, nxt_pm_req, wait_ff;
  logic [15:0] pm_addr_ff;
  logic ar_step_ff, nxt_ar_step;
  logic [6:0] ar_field_ff;
  logic [15:0] dest_hold_ff;
  logic [5:0] ctl_ff;
  logic bio_s1_ff, bio_s2_ff, bio_s3_ff, bio_lvl_ff;

  // handshake and decode
  logic opc_take, w2_take, busy, buf_push, buf_pop, space_ok, buf_in_ready;
  logic [1:0] buf_level;
  logic [2:0] occ_next;
  logic move_ind, move_issue, move_done, call_go, cc_true, zlvc_ok, tp_ok;
  logic [3:0] zlvc, cc_mask, cc_val;
  logic [15:0] live_dest, issue_addr, pc_plus1, pc_plus2;
  logic [16:0] move_words;
  logic [5:0] clr_vec;
  logic stk_push;
  logic [15:0] stk_data;
  bmc_pkg::bmc_dmw_s buf_in, buf_out;

  assign opc_take = instr_valid && instr_ready_ff && (state_ff == bmc_pkg::ST_OPC);
  assign w2_take = instr_valid && instr_ready_ff && (state_ff == bmc_pkg::ST_WORD2);
  assign cls_now = bmc_pkg::bmc_classify(instr_word);
  assign pc_plus1 = pc_ff + bmc_pkg::PC_ONE;
  assign pc_plus2 = pc_ff + bmc_pkg::PC_TWO;

  // branch pin through three flops, a change counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bio_s1_ff <= 1'b1;
      bio_s2_ff <= 1'b1;
      bio_s3_ff <= 1'b1;
      bio_lvl_ff <= 1'b1;
    end
    else
    begin
      bio_s1_ff <= bio_pin_n;
      bio_s2_ff <= bio_s1_ff;
      bio_s3_ff <= bio_s2_ff;
      if (bio_s2_ff == bio_s3_ff)
        bio_lvl_ff <= bio_s3_ff;
    end
  end

  // condition evaluation, all tested flags anded together
  assign zlvc = {acc_value == 32'h0000_0000, acc_value[bmc_pkg::ACC_W - 1], ovf_flag, ctl_ff[bmc_pkg::CTL_C]};
  assign cc_mask = opcode_ff[bmc_pkg::MASK_LSB +: 4];
  assign cc_val = opcode_ff[3:0];
  assign zlvc_ok = ((zlvc ^ cc_val) & cc_mask) == 4'h0;
  assign tp_ok = (opcode_ff[bmc_pkg::TP_LSB +: 2] == bmc_pkg::TP_NONE) ||
                 (opcode_ff[bmc_pkg::TP_LSB +: 2] == bmc_pkg::TP_BIO && !bio_lvl_ff) ||
                 (opcode_ff[bmc_pkg::TP_LSB +: 2] == bmc_pkg::TP_TC && ctl_ff[bmc_pkg::CTL_TC]) ||
                 (opcode_ff[bmc_pkg::TP_LSB +: 2] == bmc_pkg::TP_NTC && !ctl_ff[bmc_pkg::CTL_TC]);
  assign cc_true = zlvc_ok && tp_ok;
  assign call_go = w2_take && ((cls_ff == bmc_pkg::CLS_CALL) || (cls_ff == bmc_pkg::CLS_CC && cc_true));

  // block move: one program read in flight, buffer room checked ahead
  assign move_ind = opcode_ff[bmc_pkg::IND_BIT];
  assign busy = pm_req_ff || wait_ff;
  assign buf_push = busy && pm_rvalid;
  assign buf_pop = dm_valid && dm_ready;
  assign occ_next = {1'b0, buf_level} + {2'b00, buf_push} - {2'b00, buf_pop};
  assign space_ok = (occ_next <= 3'h1) && buf_in_ready;
  assign move_issue = (words_left_ff != 17'h00000) && space_ok && (!busy || pm_rvalid) &&
                      (state_ff == bmc_pkg::ST_MOVE || (w2_take && cls_ff == bmc_pkg::CLS_MOVE));
  assign move_done = (state_ff == bmc_pkg::ST_MOVE) && buf_push && (words_left_ff == 17'h00000);
  assign issue_addr = (state_ff == bmc_pkg::ST_WORD2) ? instr_word : pc_ff;
  assign move_words = rpt_pending ? ({1'b0, rpt_count} + bmc_pkg::WORDS_ONE) : bmc_pkg::WORDS_ONE;
  assign live_dest = move_ind ? aux_value : {dp_value, opcode_ff[bmc_pkg::DMA_W - 1:0]};
  assign buf_in.addr = pm_req_ff ? live_dest : dest_hold_ff;
  assign buf_in.data = pm_rdata;
  assign nxt_pm_req = move_issue;
  // of the calls only the direct call carries an aux field; bit 7 of a conditional call is a flag mask
  assign nxt_ar_step = move_issue ? move_ind :
                       (call_go && cls_ff == bmc_pkg::CLS_CALL && opcode_ff[bmc_pkg::IND_BIT]);

  // stack pushes of the three call kinds
  assign stk_push = (opc_take && cls_now == bmc_pkg::CLS_COMPUTED_SUBROUTINE_CALL) || call_go;
  assign stk_data = (state_ff == bmc_pkg::ST_OPC) ? pc_plus1 : pc_plus2;
  assign clr_vec = (opc_take && cls_now == bmc_pkg::CLS_CLEAR_CONTROL_BIT_INSTR) ? bmc_pkg::bmc_clear_control_bit_instr_sel(instr_word[3:0]) : 6'h00;

  // next state and next pc
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    unique case (state_ff)
      bmc_pkg::ST_OPC:
      begin
        if (opc_take)
        begin
          unique case (cls_now)
            bmc_pkg::CLS_MOVE, bmc_pkg::CLS_CALL, bmc_pkg::CLS_CC: nxt_state = bmc_pkg::ST_WORD2;
            bmc_pkg::CLS_COMPUTED_SUBROUTINE_CALL:
            begin
              nxt_state = bmc_pkg::ST_FLUSH;
              nxt_pc = acc_value[15:0];
            end
            bmc_pkg::CLS_CLEAR_CONTROL_BIT_INSTR, bmc_pkg::CLS_OTHER: nxt_pc = pc_plus1;
          endcase
        end
      end
      bmc_pkg::ST_WORD2:
      begin
        if (w2_take)
        begin
          if (cls_ff == bmc_pkg::CLS_MOVE)
            nxt_state = bmc_pkg::ST_MOVE;
          else if (call_go)
          begin
            nxt_state = bmc_pkg::ST_FLUSH;
            nxt_pc = instr_word;
          end
          else
          begin
            nxt_state = bmc_pkg::ST_OPC;
            nxt_pc = pc_plus2;
          end
        end
      end
      bmc_pkg::ST_MOVE:
      begin
        if (move_done)
        begin
          nxt_state = bmc_pkg::ST_OPC;
          nxt_pc = mstack_ff;
        end
      end
      bmc_pkg::ST_FLUSH:
      begin
        if (hold_ff == bmc_pkg::HOLD_LAST)
          nxt_state = bmc_pkg::ST_OPC;
      end
    endcase
    if (move_issue)
      nxt_pc = issue_addr + bmc_pkg::PC_ONE;
  end

  assign nxt_ready = (nxt_state == bmc_pkg::ST_OPC) || (nxt_state == bmc_pkg::ST_WORD2);

  // sequencing registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= bmc_pkg::ST_OPC;
      pc_ff <= '0;
      instr_ready_ff <= 1'b0;
      cls_ff <= bmc_pkg::CLS_OTHER;
      opcode_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      instr_ready_ff <= nxt_ready;
      if (opc_take)
      begin
        cls_ff <= cls_now;
        opcode_ff <= instr_word;
      end
    end
  end

  // call hold counter and discard pulse for the two prefetched words
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      hold_ff <= '0;
      flush_ff <= 1'b0;
    end
    else
    begin
      flush_ff <= stk_push;
      if (opc_take && cls_now == bmc_pkg::CLS_COMPUTED_SUBROUTINE_CALL)
        hold_ff <= bmc_pkg::HOLD_COMPUTED_SUBROUTINE_CALL;
      else if (call_go)
        hold_ff <= bmc_pkg::HOLD_CALL;
      else if (state_ff == bmc_pkg::ST_FLUSH)
        hold_ff <= hold_ff - bmc_pkg::HOLD_LAST;
    end
  end

  // move counters, program reads and interrupt hold
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      words_left_ff <= '0;
      mstack_ff <= '0;
      rpt_mode_ff <= 1'b0;
      int_hold_ff <= 1'b0;
      pm_req_ff <= 1'b0;
      pm_addr_ff <= '0;
      wait_ff <= 1'b0;
      dest_hold_ff <= '0;
    end
    else
    begin
      if (opc_take && cls_now == bmc_pkg::CLS_MOVE)
      begin
        rpt_mode_ff <= rpt_pending;
        int_hold_ff <= rpt_pending;
        words_left_ff <= move_words;
      end
      else if (move_issue)
        words_left_ff <= words_left_ff - bmc_pkg::WORDS_ONE;
      if (move_done)
        int_hold_ff <= 1'b0;
      if (w2_take && cls_ff == bmc_pkg::CLS_MOVE)
        mstack_ff <= pc_plus2;
      pm_req_ff <= nxt_pm_req;
      if (move_issue)
        pm_addr_ff <= issue_addr;
      wait_ff <= busy && !pm_rvalid;
      if (pm_req_ff)
        dest_hold_ff <= live_dest;
    end
  end

  // auxiliary step pulse and control bits, a set beats a clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ar_step_ff <= 1'b0;
      ar_field_ff <= '0;
      ctl_ff <= bmc_pkg::CTL_RESET;
    end
    else
    begin
      ar_step_ff <= nxt_ar_step;
      if (nxt_ar_step)
        ar_field_ff <= opcode_ff[bmc_pkg::ARF_W - 1:0];
      ctl_ff <= (ctl_ff & ~clr_vec) | ctl_set;
    end
  end

  bmc_stack u_stack (
    .clock(clock),
    .rst_n(rst_n),
    .push(stk_push),
    .push_data(stk_data),
    .pop(stack_pop && !stk_push),
    .stack_top_entry(stack_top)
  );

  bmc_buf u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_data(buf_in),
    .in_ready(buf_in_ready),
    .out_valid(dm_valid),
    .out_data(buf_out),
    .out_ready(dm_ready),
    .level(buf_level)
  );

  // outputs
  assign dm_addr = buf_out.addr;
  assign dm_data = buf_out.data;
  assign instr_ready = instr_ready_ff;
  assign pc_out = pc_ff;
  assign flush = flush_ff;
  assign int_hold = int_hold_ff;
  assign ar_step = ar_step_ff;
  assign ar_field = ar_field_ff;
  assign pm_req = pm_req_ff;
  assign pm_addr = pm_addr_ff;
  assign ctl_bits = ctl_ff;

  // checks
  sequence s_computed_subroutine_call_take;
    opc_take && cls_now == bmc_pkg::CLS_COMPUTED_SUBROUTINE_CALL;
  endsequence
  sequence s_cc_taken;
    w2_take && cls_ff == bmc_pkg::CLS_CC && cc_true;
  endsequence
  sequence s_single_move;
    opc_take && cls_now == bmc_pkg::CLS_MOVE && !rpt_pending ##1 w2_take ##1 (pm_req_ff && pm_rvalid && space_ok);
  endsequence

  a_computed_subroutine_call_pc_load: assert property (@(posedge clock) disable iff (!rst_n)
    s_computed_subroutine_call_take |=> pc_ff == $past(acc_value[15:0]) && stack_top == $past(pc_plus1) && flush_ff)
    else $error("computed call did not load pc or push return");
  a_computed_subroutine_call_four_cycles: assert property (@(posedge clock) disable iff (!rst_n)
    s_computed_subroutine_call_take |=> !instr_ready_ff [*3] ##1 instr_ready_ff)
    else $error("computed call not four cycles");
  a_call_push_two: assert property (@(posedge clock) disable iff (!rst_n)
    (w2_take && cls_ff == bmc_pkg::CLS_CALL) |=> pc_ff == $past(instr_word) && stack_top == $past(pc_plus2))
    else $error("direct call push or target wrong");
  a_cc_not_taken: assert property (@(posedge clock) disable iff (!rst_n)
    (w2_take && cls_ff == bmc_pkg::CLS_CC && !cc_true) |=> state_ff == bmc_pkg::ST_OPC && pc_ff == $past(pc_plus2) && !flush_ff)
    else $error("untaken conditional call misbehaved");
  a_cc_taken_time: assert property (@(posedge clock) disable iff (!rst_n)
    s_cc_taken |=> flush_ff && !instr_ready_ff ##1 !instr_ready_ff ##1 instr_ready_ff)
    else $error("taken conditional call not four cycles");
  a_move_word_count: assert property (@(posedge clock) disable iff (!rst_n)
    (opc_take && cls_now == bmc_pkg::CLS_MOVE) |=> words_left_ff == $past(move_words))
    else $error("move word count wrong");
  a_move_pc_step: assert property (@(posedge clock) disable iff (!rst_n)
    (pm_req_ff && state_ff == bmc_pkg::ST_MOVE) ##1 pm_req_ff |-> pm_addr_ff == 16'($past(pm_addr_ff) + bmc_pkg::PC_ONE))
    else $error("source address did not advance by one");
  a_move_int_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == bmc_pkg::ST_MOVE && rpt_mode_ff) |-> int_hold_ff)
    else $error("interrupts not held during repeated move");
  a_move_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == bmc_pkg::ST_MOVE && pm_req_ff && pm_rvalid && space_ok && words_left_ff != 17'h00000) |=> pm_req_ff)
    else $error("repeated move word took more than one cycle");
  a_move_direct_dest: assert property (@(posedge clock) disable iff (!rst_n)
    (buf_push && !move_ind) |-> buf_in.addr == {dp_value, opcode_ff[bmc_pkg::DMA_W - 1:0]})
    else $error("direct destination changed");
  a_move_single_time: assert property (@(posedge clock) disable iff (!rst_n)
    s_single_move |=> instr_ready_ff && state_ff == bmc_pkg::ST_OPC)
    else $error("single move not three cycles");
  a_clear_control_bit_instr_one_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (opc_take && cls_now == bmc_pkg::CLS_CLEAR_CONTROL_BIT_INSTR && ctl_set == 6'h00) |=> ctl_ff == ($past(ctl_ff) & ~$past(clr_vec)))
    else $error("clear touched other control bits");
endmodule : bmc_exec
`default_nettype wire

// File: sim/bmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_mem_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // behaviour selects
  input wire logic slow,
  input wire logic stall,
  // program read
  input wire logic pm_req,
  input wire logic [15:0] pm_addr,
  output logic pm_rvalid,
  output logic [15:0] pm_rdata,
  // data write
  output logic dm_ready
);
  logic late_ff;
  logic [15:0] last_ff;
  // zero-wait or one-wait program memory, garbage when idle
  assign pm_rvalid = slow ? late_ff : pm_req;
  assign pm_rdata = pm_rvalid ? (pm_addr ^ 16'hC3A5) : ~last_ff;
  assign dm_ready = ~stall;
  // late answer and last word driven
  always_ff @(posedge clock)
  begin
    late_ff <= rst_n & slow & pm_req;
    if (pm_rvalid)
      last_ff <= pm_rdata;
  end
endmodule : bmc_mem_model
`default_nettype wire

// File: sim/bmc_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_exec_tb;
  logic clock, rst_n, instr_valid, instr_ready, flush, int_hold, rpt_pending, ovf_flag, ar_step, pm_req;
  logic pm_rvalid, dm_valid, dm_ready, stack_pop, bio_pin_n, slow, stall, noisy, rep_mode, take;
  logic [15:0] instr_word, pc_out, rpt_count, aux_value, pm_addr, pm_rdata, dm_addr, dm_data, stack_top, pc_exp;
  logic [31:0] acc_value, seed, r, e, dq[$], cq[$];
  logic [8:0] dp_value;
  logic [6:0] ar_field, arf_exp;
  logic [5:0] ctl_set, ctl_bits, ctl_exp;
  logic [3:0] fl, sel[6];
  logic [2:0] tick;
  int n_errors, checks_done, last_k;

  bmc_exec i_bmc_exec (
    .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .pc_out(pc_out), .flush(flush), .int_hold(int_hold), .rpt_pending(rpt_pending), .rpt_count(rpt_count),
    .acc_value(acc_value), .ovf_flag(ovf_flag), .dp_value(dp_value), .aux_value(aux_value),
    .ar_step(ar_step), .ar_field(ar_field), .pm_req(pm_req), .pm_addr(pm_addr), .pm_rvalid(pm_rvalid),
    .pm_rdata(pm_rdata), .dm_valid(dm_valid), .dm_addr(dm_addr), .dm_data(dm_data), .dm_ready(dm_ready),
    .stack_pop(stack_pop), .stack_top(stack_top), .ctl_set(ctl_set), .ctl_bits(ctl_bits), .bio_pin_n(bio_pin_n)
  );
  bmc_mem_model i_bmc_mem_model (
    .clock(clock), .rst_n(rst_n), .slow(slow), .stall(stall), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_rvalid(pm_rvalid), .pm_rdata(pm_rdata), .dm_ready(dm_ready)
  );

  // clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // offer one word, held until taken
  task automatic send(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    last_k = 0;
    do
    begin
      @(posedge clock);
      last_k++;
    end
    while (instr_ready !== 1'b1 && last_k < 400);
    if (last_k >= 400)
    begin
      n_errors++;
      close_out();
    end
  endtask : send

  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  // block move, then a one-word filler to time it
  task automatic move(input logic [7:0] lo, input logic [15:0] pma, input int n, input logic timed);
    logic [15:0] a;
    a = lo[7] ? aux_value : {dp_value, lo[6:0]};
    arf_exp = lo[6:0];
    rpt_pending <= n > 1;
    rpt_count <= 16'(n - 1);
    rep_mode = n > 1;
    for (int i = 0; i < n; i++)
      dq.push_back({a + (lo[7] ? 16'(i) : 16'h0000), (pma + 16'(i)) ^ 16'hC3A5});
    send({bmc_pkg::OP_MOVE_HI, lo});
    send(pma);
    send(16'h0000);
    rep_mode = 1'b0;
    pc_exp = pc_exp + 16'h0003;
    if (timed)
      chk(16'(last_k + 1), 16'(n + 2));
  endtask : move

  // aux file, stall pattern, set pulses, and result watcher
  always @(posedge clock)
  begin
    tick <= tick + 3'h1;
    stall <= noisy & (tick != 3'h0);
    if (ctl_set != 6'h00)
      ctl_set <= 6'h00;
    if (ar_step === 1'b1)
    begin
      aux_value <= aux_value + 16'h0001;
      chk({9'h000, ar_field}, {9'h000, arf_exp});
    end
    if (pm_req === 1'b1 && rep_mode)
      chk({15'h0000, int_hold}, 16'h0001);
    if (dm_valid === 1'b1 && dm_ready === 1'b1)
    begin
      e = (dq.size() > 0) ? dq.pop_front() : 32'hFFFFFFFF;
      chk(dm_addr, e[31:16]);
      chk(dm_data, e[15:0]);
    end
    if (flush === 1'b1)
    begin
      e = (cq.size() > 0) ? cq.pop_front() : 32'hFFFFFFFF;
      chk(pc_out, e[31:16]);
      chk(stack_top, e[15:0]);
    end
  end

  // main sequence
  initial
  begin
    seed = 32'h00000025;
    {rst_n, instr_valid, rpt_pending, ovf_flag, stack_pop, slow, noisy, rep_mode, stall} = '0;
    {instr_word, rpt_count, pc_exp, acc_value, tick, ctl_set} = '0;
    bio_pin_n = 1'b1;
    aux_value = 16'h0300;
    dp_value = 9'h006;
    sel = '{bmc_pkg::SEL_C, bmc_pkg::SEL_CNF, bmc_pkg::SEL_GLOBAL_INTERRUPT_MASK, bmc_pkg::SEL_OVM, bmc_pkg::SEL_SXM, bmc_pkg::SEL_TC};
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    move(8'h15, 16'h0800, 1, 1'b1);
    move(8'h15, 16'h0900, 2, 1'b1);
    move(8'h8A, 16'h1230, 4, 1'b1);
    slow <= 1'b1;
    noisy <= 1'b1;
    move(8'h8A, 16'hFFFE, 8, 1'b0);
    idle(60);
    chk(16'(dq.size()), 16'h0000);
    slow <= 1'b0;
    noisy <= 1'b0;
    for (int j = 0; j < 6; j++)
    begin
      ctl_set <= 6'h3F;
      idle(2);
      send({bmc_pkg::OP_CLEAR_CONTROL_BIT_INSTR_HI, sel[j]});
      pc_exp = pc_exp + 16'h0001;
      idle(3);
      chk({10'h000, ctl_bits}, {10'h000, 6'h3F & ~(6'h01 << j)});
    end
    ctl_exp = 6'h1F;
    for (int j = 0; j < 24; j++)
    begin
      r = rnd();
      acc_value <= r[2] ? 32'h0 : r;
      ovf_flag <= r[4];
      bio_pin_n <= r[5];
      ctl_set <= {r[6], 5'h00};
      ctl_exp[5] = ctl_exp[5] | r[6];
      idle(6);
      fl = {r[2], r[31] & ~r[2], r[4], ctl_exp[0]};
      case (r[9:8])
        bmc_pkg::TP_BIO: take = ~r[5];
        bmc_pkg::TP_TC: take = ctl_exp[5];
        bmc_pkg::TP_NTC: take = ~ctl_exp[5];
        default: take = 1'b1;
      endcase
      take = take && (((fl ^ r[19:16]) & r[15:12] & r[23:20]) == 4'h0);
      if (take)
        cq.push_back({r[31:16], pc_exp + 16'h0002});
      pc_exp = take ? r[31:16] : pc_exp + 16'h0002;
      send({bmc_pkg::OP_CC_HI, r[9:8], r[15:12] & r[23:20], r[19:16]}); // one tp field test plus up to four flag tests per call
      send(r[31:16]);
      idle(5);
      chk(16'(cq.size()), 16'h0000);
    end
    r = rnd();
    acc_value <= r;
    cq.push_back({r[15:0], pc_exp + 16'h0001});
    pc_exp = r[15:0];
    send(bmc_pkg::OP_COMPUTED_SUBROUTINE_CALL);
    cq.push_back({r[31:16], pc_exp + 16'h0002});
    arf_exp = 7'h00;
    send({bmc_pkg::OP_CALL_HI, 8'h80});
    send(r[31:16]);
    idle(8);
    chk(16'(cq.size()), 16'h0000);
    close_out();
  end
endmodule : bmc_exec_tb
`default_nettype wire
